// File: bsp_port.sv
`default_nettype none
// Notes on behaviour
// R1: Eight data pins, each with its own direction bit.
// R2: Slave-port mode turns the data port into a byte slave port.
// R3: Three control pins with three independent direction bits.
// R4: In slave mode control pins are strobes, set as digital inputs.
// R5: Control pins selected analog read back as zero.
// R6: Control direction bits drive pin enables even while pins are analog.
// R7: After reset the control pins are analog and read zero.
// R8: Input-full bit 7 set on received unread byte, read-only.
// R9: Output-full bit 6 set while output latch holds unread byte.
// R10: Overflow bit 5 set on write while byte unread; software clears it.
// R11: Mode bit 4 selects slave port when one, GPIO when zero.
// R12: Bits 2,1,0 set chip-select, write, read pin directions; one is input.
// R13: Selected and read low: output latch drives the data pins.
// R14: Selected and write low: data pins latched into input register.
// R15: Chip select low selects; strobes act only while selected.
// R16: Control/status register resets to 0000-111.
// R17: Data port direction register resets to all ones.
// R18: Write end latches data, flags set one cycle later.
// R19: Write while input full overwrites old byte and raises overflow.
// R20: Read start clears output-full until software writes new data after the read ends.
// R21: Outside slave mode input-full and output-full held clear.
// R22: GPIO write loads output latch; read returns sampled pin levels.
module bsp_port
  import bsp_pkg::*;
#(
  parameter int unsigned WIDTH     = 8,
  parameter int unsigned CTRL_PINS = 3
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [7:0]           reg_rdata,
  input  wire logic [WIDTH-1:0]     data_pin_in,
  output var  logic [WIDTH-1:0]     data_pin_out,
  output var  logic [WIDTH-1:0]     data_pin_oe,
  input  wire logic [CTRL_PINS-1:0] ctrl_pin_in,
  output var  logic [CTRL_PINS-1:0] ctrl_pin_out,
  output var  logic [CTRL_PINS-1:0] ctrl_pin_oe,
  output var  logic                 slave_port_irq_flag
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [WIDTH+CTRL_PINS-1:0] sync1_ff;
  logic [WIDTH+CTRL_PINS-1:0] sync2_ff;
  logic [WIDTH-1:0]           pdir_ff;
  logic [WIDTH-1:0]           out_latch_ff;
  logic [WIDTH-1:0]           in_latch_ff;
  logic [WIDTH-1:0]           hold_ff;
  logic [CTRL_PINS-1:0]       ctrl_dir_ff;
  logic [CTRL_PINS-1:0]       ctrl_latch_ff;
  logic [2:0]                 acfg_ff;
  logic                       mode_ff;
  logic                       ibf_ff;
  logic                       obf_ff;
  logic                       input_overflow_flag_ff;
  logic                       wr_act_ff;
  logic                       rd_act_ff;
  logic                       wdone_ff;
  logic                       rdone_ff;
  logic [7:0]                 rdata_ff;
  logic [WIDTH-1:0]           pin_out_ff;
  logic [WIDTH-1:0]           pin_oe_ff;
  logic [CTRL_PINS-1:0]       cpin_oe_ff;
  logic                       irq_ff;

  logic [WIDTH-1:0]           pd_s;
  logic [CTRL_PINS-1:0]       pe_s;
  logic [CTRL_PINS-1:0]       pe_read;
  logic                       analog_sel;
  logic                       cs_n_s;
  logic                       wr_n_s;
  logic                       rd_n_s;
  logic                       selected;
  logic                       wr_act;
  logic                       rd_act;
  logic                       wend;
  logic                       rd_start;
  logic                       rend;
  logic                       hit_data;
  logic                       hit_ctrl;
  logic                       hit_dir;
  logic                       hit_stat;
  logic                       hit_acfg;
  logic                       wr_data;
  logic                       wr_stat;
  logic                       rd_data;
  logic [7:0]                 status_word;
  logic [7:0]                 nxt_rdata;
  logic [WIDTH-1:0]           nxt_pin_out;
  logic [WIDTH-1:0]           nxt_pin_oe;
  logic                       nxt_ibf;
  logic                       nxt_obf;
  logic                       nxt_input_overflow_flag;
  bsp_mode_t                  mode_state;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Strobes arrive from another system; only stage two is read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Strobe bits reset idle high, else a false write follows reset
      sync1_ff <= {{CTRL_PINS{1'b1}}, {WIDTH{1'b0}}};
      sync2_ff <= {{CTRL_PINS{1'b1}}, {WIDTH{1'b0}}};
    end else begin
      sync1_ff <= {ctrl_pin_in, data_pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign pd_s = sync2_ff[WIDTH-1:0];
  assign pe_s = sync2_ff[WIDTH+CTRL_PINS-1:WIDTH];

  // ****************************************************************
  // Analog selection and strobe decode
  // ****************************************************************
  assign analog_sel = (acfg_ff < ACFG_DIGITAL_MIN);         // [R7]
  assign pe_read    = analog_sel ? '0 : pe_s;               // [R5]
  assign mode_state = mode_ff ? BSP_PSP : BSP_GPIO;         // [R11]
  // Strobes read as digital so a stray analog setting cannot stall it
  assign cs_n_s     = pe_s[BIT_CS_DIR];                     // [R4]
  assign wr_n_s     = pe_s[BIT_WR_DIR];
  assign rd_n_s     = pe_s[BIT_RD_DIR];
  assign selected   = (mode_state == BSP_PSP) && !cs_n_s;   // [R15]
  assign wr_act     = selected && !wr_n_s;                  // [R14]
  assign rd_act     = selected && !rd_n_s;                  // [R13]
  assign wend       = wr_act_ff && !wr_act;                 // [R18]
  assign rd_start   = rd_act && !rd_act_ff;                 // [R20]
  assign rend       = rd_act_ff && !rd_act;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign hit_data = (reg_addr == OFS_PORT_DATA);
  assign hit_ctrl = (reg_addr == OFS_CTRL_DATA);
  assign hit_dir  = (reg_addr == OFS_PORT_DIR);
  assign hit_stat = (reg_addr == OFS_STATUS);
  assign hit_acfg = (reg_addr == OFS_ANALOG_CFG);
  assign wr_data  = reg_wr && hit_data;
  assign wr_stat  = reg_wr && hit_stat;
  assign rd_data  = reg_rd && hit_data;

  assign status_word = {ibf_ff, obf_ff, input_overflow_flag_ff, mode_ff, 1'b0,
                        ctrl_dir_ff};                        // [R16]

  assign nxt_rdata =
      !reg_rd  ? RDATA_IDLE :
      hit_data ? (mode_ff ? in_latch_ff : pd_s) :           // [R22]
      hit_ctrl ? {5'h00, pe_read} :                         // [R5]
      hit_dir  ? pdir_ff :
      hit_stat ? status_word :                              // [R8] [R9]
      hit_acfg ? {5'h00, acfg_ff} :
                 RDATA_IDLE;

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pdir_ff       <= RST_PORT_DIR;                        // [R17]
      ctrl_dir_ff   <= RST_CTRL_DIR;                        // [R16]
      mode_ff       <= 1'b0;
      acfg_ff       <= RST_ANALOG_CFG;                      // [R7]
      out_latch_ff  <= RST_PORT_LATCH;
      ctrl_latch_ff <= RST_CTRL_LATCH;
    end else begin
      if (hit_dir && reg_wr) begin
        pdir_ff <= reg_wdata;                               // [R1]
      end
      if (wr_stat) begin
        mode_ff     <= reg_wdata[BIT_MODE];                 // [R2] [R11]
        ctrl_dir_ff <= reg_wdata[BIT_CS_DIR:BIT_RD_DIR];    // [R12]
      end
      if (hit_acfg && reg_wr) begin
        acfg_ff <= reg_wdata[2:0];
      end
      if (wr_data) begin
        out_latch_ff <= reg_wdata;                          // [R22]
      end
      if (hit_ctrl && reg_wr) begin
        ctrl_latch_ff <= reg_wdata[CTRL_PINS-1:0];
      end
    end
  end

  // ****************************************************************
  // Slave port flags
  // ****************************************************************
  // Hardware set wins over a software clear in the same cycle, but GPIO mode still clears input-full
  assign nxt_ibf  = !mode_ff  ? 1'b0 :                      // [R21]
                    wdone_ff  ? 1'b1 :                      // [R8] [R18]
                    rd_data   ? 1'b0 : ibf_ff;
  // Write during an external read leaves the flag clear
  assign nxt_obf  = !mode_ff  ? 1'b0 :                      // [R21]
                    rd_act    ? 1'b0 :                      // [R20]
                    wr_data   ? 1'b1 : obf_ff;              // [R9]
  assign nxt_input_overflow_flag = (wdone_ff && ibf_ff) ? 1'b1 :           // [R10] [R19]
                    wr_stat ? reg_wdata[BIT_INPUT_OVERFLOW_FLAG] : input_overflow_flag_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ibf_ff    <= 1'b0;
      obf_ff    <= 1'b0;
      input_overflow_flag_ff   <= 1'b0;
      wr_act_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      wdone_ff  <= 1'b0;
      rdone_ff  <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      ibf_ff    <= nxt_ibf;
      obf_ff    <= nxt_obf;
      input_overflow_flag_ff   <= nxt_input_overflow_flag;
      wr_act_ff <= wr_act;
      rd_act_ff <= rd_act;
      wdone_ff  <= wend;                                    // [R18]
      rdone_ff  <= rend;
      irq_ff    <= wdone_ff || rdone_ff;
    end
  end

  // ****************************************************************
  // Input latch
  // ****************************************************************
  // Data held from the last low-strobe cycle, not the release edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_ff     <= RST_PORT_LATCH;
      in_latch_ff <= RST_PORT_LATCH;
    end else begin
      if (wr_act) begin
        hold_ff <= pd_s;                                    // [R14]
      end
      if (wend) begin
        in_latch_ff <= hold_ff;                             // [R19]
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  assign nxt_pin_out = mode_ff ? out_latch_ff : out_latch_ff;
  assign nxt_pin_oe  = mode_ff ? {WIDTH{rd_act}} :          // [R13]
                                 ~pdir_ff;                  // [R1]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out_ff <= RST_PORT_LATCH;
      pin_oe_ff  <= '0;
      cpin_oe_ff <= '0;
      rdata_ff   <= RDATA_IDLE;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      cpin_oe_ff <= ~ctrl_dir_ff;                           // [R3] [R6]
      rdata_ff   <= nxt_rdata;
    end
  end

  assign data_pin_out        = pin_out_ff;
  assign data_pin_oe         = pin_oe_ff;
  assign ctrl_pin_out        = ctrl_latch_ff;
  assign ctrl_pin_oe         = cpin_oe_ff;
  assign reg_rdata           = rdata_ff;
  assign slave_port_irq_flag = irq_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_GPIO_DRIVE: assert property ( // [R1]
    !mode_ff |=> (data_pin_oe == ~$past(pdir_ff)))
    else $error("GPIO pin enables do not follow direction");

  AST_PSP_RELEASE: assert property ( // [R2]
    (mode_ff && !rd_act) |=> (data_pin_oe == '0))
    else $error("Data pins driven in slave mode without read");

  AST_CTRL_DIR: assert property ( // [R3]
    ##1 (ctrl_pin_oe == ~$past(ctrl_dir_ff)))
    else $error("Control pin enables do not follow direction");

  AST_ANALOG_ZERO: assert property ( // [R5]
    (reg_rd && hit_ctrl && analog_sel) |=> (reg_rdata == 8'h00))
    else $error("Analog control pins did not read zero");

  AST_IBF_SET: assert property ( // [R18]
    (wend && mode_ff) ##1 mode_ff |=> ibf_ff)
    else $error("Input-full not set after write end");

  AST_OBF_CLEAR: assert property ( // [R20]
    (rd_start && mode_ff) |=> !obf_ff [*2])
    else $error("Output-full not cleared at read start");

  AST_INPUT_OVERFLOW_FLAG_SET: assert property ( // [R10]
    (wdone_ff && ibf_ff) |=> input_overflow_flag_ff)
    else $error("Overflow not set on write while full");

  AST_MODE_IDLE: assert property ( // [R21]
    (!mode_ff && !wr_stat) |=> (!ibf_ff && !obf_ff && $stable(input_overflow_flag_ff)))
    else $error("Flags not held in GPIO mode");

  AST_READ_DRIVE: assert property ( // [R13]
    rd_act |=> ((data_pin_oe == '1)
                && (data_pin_out == $past(out_latch_ff))))
    else $error("Output latch not driven during read");

  AST_LATCH_WRITE: assert property ( // [R14]
    wend |=> (in_latch_ff == $past(hold_ff)))
    else $error("Input latch missed written byte");

  AST_STATUS_READ: assert property ( // [R16]
    (reg_rd && hit_stat) |=> ((reg_rdata[3] == 1'b0)
      && (reg_rdata[BIT_MODE] == $past(mode_ff))))
    else $error("Status read does not show mode");

  AST_EVENT_PULSE: assert property ( // [R18]
    wend ##1 1'b1 |=> slave_port_irq_flag)
    else $error("Event pulse missing after write end");

  AST_OBF_SET: assert property ( // [R9]
    (mode_ff && wr_data && !rd_act) |=> obf_ff)
    else $error("Output-full not set by software write");

  AST_IBF_CLEAR: assert property ( // [R8]
    (mode_ff && rd_data && !wdone_ff) |=> !ibf_ff)
    else $error("Input-full not cleared by data read");

  AST_DESELECT: assert property ( // [R15]
    (mode_ff && cs_n_s) |=> (data_pin_oe == '0))
    else $error("Data pins driven while deselected");

  AST_OVERWRITE: assert property ( // [R19]
    (wdone_ff && ibf_ff && mode_ff) |=> (ibf_ff && input_overflow_flag_ff))
    else $error("Overwrite did not keep full and overflow set");

  AST_GPIO_READ: assert property ( // [R22]
    (reg_rd && hit_data && !mode_ff) |=> (reg_rdata == $past(pd_s)))
    else $error("GPIO data read does not show pin levels");

  AST_DIR_READ: assert property ( // [R12]
    (reg_rd && hit_stat) |=>
      (reg_rdata[BIT_CS_DIR:BIT_RD_DIR] == $past(ctrl_dir_ff)))
    else $error("Status read does not show pin directions");

  AST_PDIR_READ: assert property ( // [R1]
    (reg_rd && hit_dir) |=> (reg_rdata == $past(pdir_ff)))
    else $error("Direction read does not match register");

  AST_INPUT_OVERFLOW_FLAG_HOLD: assert property ( // [R10]
    (!(wdone_ff && ibf_ff) && !wr_stat) |=> $stable(input_overflow_flag_ff))
    else $error("Overflow changed without cause");

  AST_MODE_WRITE: assert property ( // [R11]
    wr_stat |=> (mode_ff == $past(reg_wdata[BIT_MODE])))
    else $error("Mode bit did not take written value");

  COV_WRITE: cover property (wend ##2 ibf_ff);
  COV_OVERFLOW: cover property (wdone_ff && ibf_ff);
  COV_READ: cover property (rd_start && obf_ff);
  COV_GPIO: cover property (!mode_ff && rd_data);

endmodule
`default_nettype wire

// File: bsp_pkg.sv
`default_nettype none
// ****************************************************************
// Byte slave port: shared constants
// ****************************************************************
package bsp_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PORT_DATA   = 8'h08;
  localparam logic [7:0] OFS_CTRL_DATA   = 8'h09;
  localparam logic [7:0] OFS_PORT_DIR    = 8'h88;
  localparam logic [7:0] OFS_STATUS      = 8'h89;
  localparam logic [7:0] OFS_ANALOG_CFG  = 8'h9F;

  // ****************************************************************
  // Control and status field positions
  // ****************************************************************
  localparam int unsigned BIT_IBF        = 7;
  localparam int unsigned BIT_OBF        = 6;
  localparam int unsigned BIT_INPUT_OVERFLOW_FLAG       = 5;
  localparam int unsigned BIT_MODE       = 4;
  localparam int unsigned BIT_CS_DIR     = 2;
  localparam int unsigned BIT_WR_DIR     = 1;
  localparam int unsigned BIT_RD_DIR     = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_PORT_DIR    = 8'hFF;
  localparam logic [2:0] RST_CTRL_DIR    = 3'h7;
  localparam logic [2:0] RST_ANALOG_CFG  = 3'h0;
  localparam logic [7:0] RST_PORT_LATCH  = 8'h00;
  localparam logic [2:0] RST_CTRL_LATCH  = 3'h0;

  // ****************************************************************
  // Analog configuration, read idle value and modes
  // ****************************************************************
  // Codes at or above this make all three control pins digital
  localparam logic [2:0] ACFG_DIGITAL_MIN = 3'h6;
  localparam logic [7:0] RDATA_IDLE       = 8'h00;

  typedef enum logic [1:0] {
    BSP_GPIO = 2'b01,
    BSP_PSP  = 2'b10
  } bsp_mode_t;

endpackage
`default_nettype wire

// File: bsp_host_model.sv
`default_nettype none
module bsp_host_model (
  input  wire logic       clk,
  output var  logic [2:0] host_ctrl,
  output var  logic [7:0] host_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************
  // Idle bus
  // ********************
  // Strobes idle high, chip deselected
  initial begin
    host_ctrl = 3'h7;
    host_data = 8'h00;
  end

  task automatic bus_drive(input logic [7:0] v);
    @(posedge clk);
    host_data <= v;
  endtask

  // ********************
  // Transfers
  // ********************
  // Strobe held 4 clocks, data kept 3 more
  task automatic ext_write(input logic cs_n, input logic [7:0] v);
    @(posedge clk);
    host_data <= v;
    host_ctrl <= {cs_n, 2'b01};
    repeat (4) @(posedge clk);
    host_ctrl <= 3'h7;
    repeat (3) @(posedge clk);
    // Released lines flip, so a stale byte cannot pass
    host_data <= ~v;
    repeat (4) @(posedge clk);
  endtask

  // Read kept low until the bench ends it
  task automatic rd_begin;
    @(posedge clk);
    host_ctrl <= 3'h2;
  endtask

  task automatic rd_end;
    @(posedge clk);
    host_ctrl <= 3'h7;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: bsp_port_tb.sv
`default_nettype none
module bsp_port_tb
  import bsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       resetn;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] data_pin_in;
  logic [7:0] data_pin_out;
  logic [7:0] data_pin_oe;
  logic [2:0] ctrl_pin_in;
  logic [2:0] ctrl_pin_out;
  logic [2:0] ctrl_pin_oe;
  logic       slave_port_irq_flag;
  logic [2:0] host_ctrl;
  logic [7:0] host_data;
  logic [7:0] irq_count;
  int         miscompares;
  int         n_checks;
  int         cycles;

  // ********************
  // Pin resolution
  // ********************
  // Device enable wins, otherwise the host level
  assign data_pin_in = (data_pin_oe & data_pin_out)
                     | (~data_pin_oe & host_data);
  assign ctrl_pin_in = (ctrl_pin_oe & ctrl_pin_out)
                     | (~ctrl_pin_oe & host_ctrl);

  bsp_port DUT (
    .clk                 (clk),
    .resetn              (resetn),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .data_pin_in         (data_pin_in),
    .data_pin_out        (data_pin_out),
    .data_pin_oe         (data_pin_oe),
    .ctrl_pin_in         (ctrl_pin_in),
    .ctrl_pin_out        (ctrl_pin_out),
    .ctrl_pin_oe         (ctrl_pin_oe),
    .slave_port_irq_flag (slave_port_irq_flag)
  );

  bsp_host_model host (
    .clk       (clk),
    .host_ctrl (host_ctrl),
    .host_data (host_data)
  );

  // ********************
  // Tasks
  // ********************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check("register read", exp, reg_rdata);
  endtask

  // ********************
  // Clock, irq count, timeout
  // ********************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (slave_port_irq_flag === 1'b1) begin
      irq_count <= irq_count + 8'h01;
    end
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  // ********************
  // Sequence
  // ********************
  initial begin
    resetn      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    irq_count   = 8'h00;
    miscompares = 0;
    n_checks    = 0;
    cycles      = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    reg_check(OFS_STATUS, 8'h07);
    reg_check(OFS_PORT_DIR, 8'hFF);
    reg_check(OFS_CTRL_DATA, 8'h00);
    check("data enables", 8'h00, data_pin_oe);
    check("ctrl enables", 8'h00, {5'h00, ctrl_pin_oe});
    reg_write(8'h55, 8'hFF);
    reg_check(8'h55, 8'h00);
    // Mixed directions: low nibble driven, high nibble from host
    host.bus_drive(8'h3C);
    reg_write(OFS_PORT_DIR, 8'hF0);
    reg_write(OFS_PORT_DATA, 8'hA5);
    repeat (4) @(posedge clk);
    #1;
    check("data enables", 8'h0F, data_pin_oe);
    reg_check(OFS_PORT_DATA, 8'h35);
    reg_write(OFS_PORT_DIR, 8'hFF);
    reg_write(OFS_ANALOG_CFG, 8'h06);
    reg_write(OFS_STATUS, 8'h05);
    reg_write(OFS_CTRL_DATA, 8'h05);
    repeat (4) @(posedge clk);
    #1;
    check("ctrl enables", 8'h02, {5'h00, ctrl_pin_oe});
    check("ctrl drive", 8'h05, {5'h00, ctrl_pin_out});
    reg_check(OFS_CTRL_DATA, 8'h05);
    reg_write(OFS_ANALOG_CFG, 8'h05);
    reg_check(OFS_CTRL_DATA, 8'h00);
    check("ctrl enables", 8'h02, {5'h00, ctrl_pin_oe});
    reg_write(OFS_ANALOG_CFG, 8'h06);
    reg_write(OFS_STATUS, 8'h17);
    reg_write(OFS_PORT_DATA, 8'h5A);
    reg_check(OFS_STATUS, 8'h57);
    host.rd_begin();
    repeat (4) @(posedge clk);
    #1;
    check("data enables", 8'hFF, data_pin_oe);
    check("data drive", 8'h5A, data_pin_out);
    reg_check(OFS_STATUS, 8'h17);
    // New byte during a read goes straight out, full flag stays clear
    reg_write(OFS_PORT_DATA, 8'hC6);
    @(posedge clk);
    #1;
    check("data drive", 8'hC6, data_pin_out);
    host.rd_end();
    #1;
    check("data enables", 8'h00, data_pin_oe);
    reg_check(OFS_STATUS, 8'h17);
    host.ext_write(1'b0, 8'h3C);
    reg_check(OFS_STATUS, 8'h97);
    check("irq pulses", 8'h02, irq_count);
    host.ext_write(1'b0, 8'hC3);
    reg_check(OFS_STATUS, 8'hB7);
    reg_check(OFS_PORT_DATA, 8'hC3);
    reg_check(OFS_STATUS, 8'h37);
    // Read-only and unimplemented bits ignore the write
    reg_write(OFS_STATUS, 8'hDF);
    reg_check(OFS_STATUS, 8'h17);
    host.ext_write(1'b1, 8'h66);
    reg_check(OFS_STATUS, 8'h17);
    check("irq pulses", 8'h03, irq_count);
    reg_write(OFS_PORT_DATA, 8'h11);
    reg_write(OFS_STATUS, 8'h27);
    reg_check(OFS_STATUS, 8'h27);
    host.ext_write(1'b0, 8'h77);
    reg_check(OFS_STATUS, 8'h27);
    reg_check(OFS_PORT_DATA, 8'h88);
    // Second reset mid-run must restore status, port direction and control data reads
    @(posedge clk);
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    reg_check(OFS_STATUS, 8'h07);
    reg_check(OFS_PORT_DIR, 8'hFF);
    reg_check(OFS_CTRL_DATA, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
